// ### core/kss_config.sv
// Purpose: serial configuration port and digital knock processing chain
// Assumes: pins sampled on clock; reset stands for power-up
// Notes:   advanced command set not implemented, only its entry
`timescale 1ns/1ps
module kss_config #(
    parameter int SAMPLE_W = 10,
    parameter int ACC_W    = 32
) (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                chip_select_n,
    input  wire logic                sclk,
    input  wire logic                sdi,
    input  wire logic                int_hold,
    input  wire logic                test_n,
    input  wire logic                oscillator_input,
    input  wire logic [SAMPLE_W-1:0] sensor_one_positive_input,
    input  wire logic [SAMPLE_W-1:0] sensor_two_positive_input,
    output logic                     sdo_q,
    output logic                     sdo_oe_q,
    output logic      [5:0]          gain_q,
    output logic      [5:0]          freq_q,
    output logic      [4:0]          tc_q,
    output logic      [3:0]          presc_q,
    output logic                     chan_q,
    output logic                     advanced_q,
    output logic                     test_mode_q,
    output logic                     sample_tick_q,
    output logic      [9:0]          dac_q
);
    initial begin
        if (SAMPLE_W < 2 || ACC_W < SAMPLE_W + 16 || ACC_W > 48) begin
            $error("kss_config: unsupported sample or accumulator width");
        end
    end

    localparam int DAC_W = 10;

    logic [2:0]                 pins_s;
    logic                       cs_s;
    logic                       sclk_s;
    logic                       sdi_s;
    logic                       cs_d;
    logic                       sclk_d;
    logic                       cs_fall;
    logic                       cs_rise;
    logic                       sclk_fall;
    kss_pkg::kss_state_t        st_q;
    logic [kss_pkg::CNT_W-1:0]  bit_cnt_q;
    logic [7:0]                 shift_q;
    logic [7:0]                 latch_q;
    logic                       blocked_q;
    logic                       frame_ok;
    logic [7:0]                 div_cnt_q;
    logic [7:0]                 div_max;
    logic                       osc_d;
    logic                       int_d;
    logic [SAMPLE_W-1:0]        smp;
    logic [SAMPLE_W-1:0]        mag;
    logic [ACC_W-1:0]           acc_q;
    logic [ACC_W-1:0]           scaled;

    // select, clock and data pins into the clock domain before their edge detection
    kss_sync #(
        .WIDTH  (3),
        .STAGES (kss_pkg::SYNC_STAGES)
    ) u_sync (
        .clock   (clock),
        .rstn    (rstn),
        .rst_val (3'h5), // select high, clock low, data high: idle pins
        .din     ({chip_select_n, sclk, sdi}),
        .dout    (pins_s)
    );

    assign cs_s   = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // delayed copies for edge detection
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cs_d   <= 1'b1;
            sclk_d <= 1'b0;
            osc_d  <= 1'b0;
            int_d  <= 1'b0;
        end else begin
            cs_d   <= cs_s;
            sclk_d <= sclk_s;
            osc_d  <= oscillator_input;
            int_d  <= int_hold;
        end
    end

    assign cs_fall   = cs_d & ~cs_s;
    assign cs_rise   = ~cs_d & cs_s;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign frame_ok  = (bit_cnt_q == 4'(kss_pkg::FRAME_BITS)) && !blocked_q;

    // frame sequencer
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q <= kss_pkg::KSS_IDLE;
        end else begin
            unique case (st_q)
                kss_pkg::KSS_IDLE: begin
                    if (cs_fall) begin
                        st_q <= kss_pkg::KSS_SHIFT;
                    end
                end
                kss_pkg::KSS_SHIFT: begin
                    if (cs_rise) begin
                        st_q <= frame_ok ? kss_pkg::KSS_COMMIT : kss_pkg::KSS_IDLE;
                    end
                end
                kss_pkg::KSS_COMMIT: begin
                    st_q <= kss_pkg::KSS_IDLE;
                end
                default: begin
                    st_q <= kss_pkg::KSS_IDLE;
                end
            endcase
        end
    end

    // bit counter saturates above eight, shifter takes msb first
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bit_cnt_q <= '0;
            shift_q   <= 8'h00;
        end else if (st_q == kss_pkg::KSS_IDLE) begin
            bit_cnt_q <= '0;
        end else if (st_q == kss_pkg::KSS_SHIFT && sclk_fall) begin
            shift_q <= {shift_q[6:0], sdi_s};
            if (bit_cnt_q <= 4'(kss_pkg::FRAME_BITS)) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // frame blocked by integrate mode or test mode at any point
    always_ff @(posedge clock) begin
        if (!rstn) begin
            blocked_q <= 1'b0;
        end else if (st_q == kss_pkg::KSS_IDLE) begin
            blocked_q <= int_hold | ~test_n;
        end else if (int_hold || !test_n) begin
            blocked_q <= 1'b1;
        end
    end

    // holding latch loads on a valid select rise
    always_ff @(posedge clock) begin
        if (!rstn) begin
            latch_q <= 8'h00;
        end else if (st_q == kss_pkg::KSS_SHIFT && cs_rise && frame_ok) begin
            latch_q <= shift_q;
        end
    end

    // command decode into configuration
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gain_q     <= kss_pkg::GAIN_RST;
            freq_q     <= kss_pkg::FREQ_RST;
            tc_q       <= kss_pkg::TC_RST;
            presc_q    <= kss_pkg::PRESC_RST;
            chan_q     <= kss_pkg::CHAN_RST;
            advanced_q <= 1'b0;
        end else if (st_q == kss_pkg::KSS_COMMIT && !advanced_q) begin
            if (latch_q == kss_pkg::OP_ADVANCED) begin
                advanced_q <= 1'b1;
            end else if (latch_q[7:5] == kss_pkg::OP_PRESC) begin
                if (latch_q[4:1] <= kss_pkg::PRESC_MAX) begin
                    presc_q <= latch_q[4:1];
                end
            end else if (latch_q[7:1] == kss_pkg::OP_CHAN) begin
                chan_q <= latch_q[0];
            end else if (latch_q[7:6] == kss_pkg::OP_FREQ) begin
                freq_q <= latch_q[5:0];
            end else if (latch_q[7:6] == kss_pkg::OP_GAIN) begin
                gain_q <= latch_q[5:0];
            end else if (latch_q[7:5] == kss_pkg::OP_TC) begin
                tc_q <= latch_q[4:0];
            end
        end
    end

    // tri-state bit from the prescaler command
    logic tri_q;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tri_q <= kss_pkg::TRI_RST;
        end else if (st_q == kss_pkg::KSS_COMMIT && !advanced_q
                     && latch_q[7:5] == kss_pkg::OP_PRESC
                     && latch_q[4:1] <= kss_pkg::PRESC_MAX) begin
            tri_q <= latch_q[0];
        end
    end

    // serial output: echo in default mode, enable from select and tri-state
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_oe_q <= !cs_s && !tri_q;
        end
    end

    logic sdo_d;
    assign sdo_d = advanced_q ? 1'b0 : sdi_s;

    // test mode status, registered
    always_ff @(posedge clock) begin
        if (!rstn) begin
            test_mode_q <= 1'b0;
        end else begin
            test_mode_q <= ~test_n;
        end
    end

    // prescaler on oscillator edges makes the sampling tick
    assign div_max = 8'(kss_pkg::osc_khz(presc_q) / kss_pkg::SAMPLE_KHZ - 1);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            div_cnt_q     <= 8'h00;
            sample_tick_q <= 1'b0;
        end else begin
            sample_tick_q <= 1'b0;
            if (oscillator_input && !osc_d) begin
                if (div_cnt_q >= div_max) begin
                    div_cnt_q     <= 8'h00;
                    sample_tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 8'h01;
                end
            end
        end
    end

    // channel mux and full-wave rectification of signed samples
    assign smp = chan_q ? sensor_two_positive_input : sensor_one_positive_input;
    assign mag = smp[SAMPLE_W-1] ? SAMPLE_W'(-smp) : smp;

    // integrator: clear at window start, accumulate while integrating
    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_q <= '0;
        end else if (int_hold && !int_d) begin
            acc_q <= '0;
        end else if (int_hold && sample_tick_q) begin
            acc_q <= acc_q + ACC_W'(mag) * ACC_W'(7'(gain_q) + 7'h01);
        end
    end

    // scale by time constant and clamp to converter range
    assign scaled = acc_q >> tc_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            dac_q <= 10'h000;
        end else if (!int_hold) begin
            dac_q <= (scaled > ACC_W'(10'h3FF)) ? 10'h3FF : scaled[DAC_W-1:0];
        end
    end

    // echo register, resets to the data line's pull-up level
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sdo_q <= 1'b1;
        end else begin
            sdo_q <= sdo_d;
        end
    end

    property p_oe_off;
        @(posedge clock) disable iff (!rstn)
        sdo_oe_q |-> !$past(cs_s) && !$past(tri_q);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");

    property p_tri;
        @(posedge clock) disable iff (!rstn)
        tri_q && $past(tri_q) |-> !sdo_oe_q;
    endproperty
    a_tri: assert property (p_tri) else $error("tri-state did not win");

    property p_echo;
        @(posedge clock) disable iff (!rstn)
        !advanced_q ##1 !advanced_q |-> sdo_q == $past(sdi_s);
    endproperty
    a_echo: assert property (p_echo) else $error("echo mismatch");

    property p_shift;
        @(posedge clock) disable iff (!rstn)
        st_q == kss_pkg::KSS_SHIFT && sclk_fall |=> shift_q[0] == $past(sdi_s);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted in");

    property p_discard;
        @(posedge clock) disable iff (!rstn)
        st_q == kss_pkg::KSS_SHIFT && cs_rise && bit_cnt_q != 4'h8
        |=> st_q == kss_pkg::KSS_IDLE ##1 $stable(gain_q) && $stable(tc_q);
    endproperty
    a_discard: assert property (p_discard) else $error("bad frame applied");

    property p_latch;
        @(posedge clock) disable iff (!rstn)
        st_q == kss_pkg::KSS_SHIFT && cs_rise && frame_ok
        |=> st_q == kss_pkg::KSS_COMMIT && latch_q == $past(shift_q);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not loaded");

    property p_block;
        @(posedge clock) disable iff (!rstn)
        st_q == kss_pkg::KSS_SHIFT && (int_hold || !test_n) |=> blocked_q;
    endproperty
    a_block: assert property (p_block) else $error("frame not blocked");

    property p_clear;
        @(posedge clock) disable iff (!rstn)
        $rose(int_hold) |=> acc_q == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("integrator not cleared");

    property p_adv;
        @(posedge clock) disable iff (!rstn)
        advanced_q |=> advanced_q [*2];
    endproperty
    a_adv: assert property (p_adv) else $error("advanced mode left");

    property p_tick;
        @(posedge clock) disable iff (!rstn)
        sample_tick_q |=> !sample_tick_q [*3];
    endproperty
    a_tick: assert property (p_tick) else $error("tick too frequent");
endmodule // kss_config

// ### core/kss_pkg.sv
// Purpose: shared constants for the knock sensor serial configuration block
// Assumes: 8-bit frames, msb first, default command set only
// Notes:   oscillator codes map to kHz; sample rate fixed at 200 kHz
package kss_pkg;
    localparam int          FRAME_BITS   = 8;
    localparam int          CNT_W        = 4;
    localparam int          SAMPLE_KHZ   = 200;
    localparam int          SYNC_STAGES  = 2;
    // opcode prefixes and their widths
    localparam logic [2:0]  OP_PRESC     = 3'h2;   // 010 xxxxx
    localparam logic [6:0]  OP_CHAN      = 7'h70;  // 1110000 x
    localparam logic [1:0]  OP_FREQ      = 2'h0;   // 00 xxxxxx
    localparam logic [1:0]  OP_GAIN      = 2'h2;   // 10 xxxxxx
    localparam logic [2:0]  OP_TC        = 3'h6;   // 110 xxxxx
    localparam logic [7:0]  OP_ADVANCED  = 8'h71;  // 0111 0001
    localparam logic [3:0]  PRESC_MAX    = 4'h8;
    // reset values of the configuration
    localparam logic [5:0]  GAIN_RST     = 6'h00;
    localparam logic [5:0]  FREQ_RST     = 6'h00;
    localparam logic [4:0]  TC_RST       = 5'h00;
    localparam logic [3:0]  PRESC_RST    = 4'h0;
    localparam logic        TRI_RST      = 1'b0;
    localparam logic        CHAN_RST     = 1'b0;

    typedef enum logic [2:0] {
        KSS_IDLE   = 3'b001,
        KSS_SHIFT  = 3'b010,
        KSS_COMMIT = 3'b100
    } kss_state_t;

    // oscillator frequency in kHz for each prescaler code
    function automatic int osc_khz(input logic [3:0] code);
        case (code)
            4'h0:    osc_khz = 4000;
            4'h1:    osc_khz = 5000;
            4'h2:    osc_khz = 6000;
            4'h3:    osc_khz = 8000;
            4'h4:    osc_khz = 10000;
            4'h5:    osc_khz = 12000;
            4'h6:    osc_khz = 16000;
            4'h7:    osc_khz = 20000;
            default: osc_khz = 24000;
        endcase
    endfunction
endpackage

// ### core/kss_sync.sv
// Purpose: multi-stage synchroniser for a vector of level inputs
// Assumes: each bit is an independent level
// Notes:   only the last stage may be read outside
`timescale 1ns/1ps
module kss_sync #(
    parameter int WIDTH  = 3,
    parameter int STAGES = 2
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] rst_val,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("kss_sync: needs at least two stages");
        end
    end

    logic [WIDTH-1:0] stage_q [STAGES];

    // stage chain, first stage only feeds the second
    genvar g;
    for (g = 0; g < STAGES; g++) begin : g_stage
        always_ff @(posedge clock) begin
            if (!rstn) begin
                stage_q[g] <= rst_val;
            end else begin
                stage_q[g] <= (g == 0) ? din : stage_q[(g == 0) ? 0 : g-1];
            end
        end
    end

    // only the last stage leaves the module
    assign dout = stage_q[STAGES-1];
endmodule // kss_sync

// ### sim/knock_sensor_spi_config_bench.sv
// Purpose: self-checking bench for the knock sensor configuration block
// Assumes: 250 MHz clock; oscillator pin toggled every two clocks
// Notes:   echo is read back by the host model before each falling clock
`timescale 1ns/1ps
module knock_sensor_spi_config_bench;
    logic       clock;
    logic       rstn;
    logic       chip_select_n, sclk, sdi, int_hold, test_n, oscillator_input;
    logic [9:0] s1, s2, dac_q;
    logic [5:0] gain_q, freq_q;
    logic [4:0] tc_q;
    logic [3:0] presc_q;
    logic       sdo_q, sdo_oe_q, chan_q, advanced_q, test_mode_q, sample_tick_q;
    logic [1:0] osc_div;
    int         n_fail, n_compared, nt;

    kss_config i_kss_config (.clock(clock), .rstn(rstn), .chip_select_n(chip_select_n),
        .sclk(sclk), .sdi(sdi), .int_hold(int_hold), .test_n(test_n),
        .oscillator_input(oscillator_input), .sensor_one_positive_input(s1),
        .sensor_two_positive_input(s2), .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q),
        .gain_q(gain_q), .freq_q(freq_q), .tc_q(tc_q), .presc_q(presc_q),
        .chan_q(chan_q), .advanced_q(advanced_q), .test_mode_q(test_mode_q),
        .sample_tick_q(sample_tick_q), .dac_q(dac_q));

    kss_host i_kss_host (.clock(clock), .chip_select_n(chip_select_n), .sclk(sclk),
        .sdi(sdi), .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // oscillator pin: one rising edge every four clocks
    always @(posedge clock) begin
        osc_div          <= osc_div + 2'h1;
        oscillator_input <= osc_div[1];
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_cfg(input logic [5:0] g, input logic [5:0] f, input logic [4:0] t,
                             input logic [3:0] p, input logic c);
        check("gain", {4'h0, g}, {4'h0, gain_q});
        check("freq", {4'h0, f}, {4'h0, freq_q});
        check("tc", {5'h00, t}, {5'h00, tc_q});
        check("presc", {6'h00, p}, {6'h00, presc_q});
        check("chan", {9'h000, c}, {9'h000, chan_q});
    endtask

    task automatic send(input logic [7:0] b);
        i_kss_host.shift_bits({1'b0, b}, 8);
        if (i_kss_host.oe_all && !advanced_q) begin
            check("echo", {2'h0, b}, {2'h0, i_kss_host.echo});
        end
        i_kss_host.end_frame();
    endtask

    // integrate window of len clocks, counting sample ticks
    // windows are far shorter than real ones to keep the run short
    task automatic window(input int len);
        int_hold <= 1'b1;
        nt = 0;
        repeat (len) begin
            @(posedge clock);
            if (sample_tick_q === 1'b1) nt++;
        end
        int_hold <= 1'b0;
        repeat (12) @(posedge clock);
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        n_fail = 0;
        n_compared = 0;
        osc_div = 2'h0;
        oscillator_input = 1'b0;
        int_hold = 1'b0;
        test_n = 1'b1;
        s1 = 10'h338;
        s2 = 10'h000;
        rstn = 1'b0;
        do_reset();
        check_cfg(6'h00, 6'h00, 5'h00, 4'h0, 1'b0);
        check("advanced", 10'h000, {9'h000, advanced_q});
        check("oe idle", 10'h000, {9'h000, sdo_oe_q});
        window(960);
        check("dac clamp", 10'h3FF, dac_q);
        check("ticks", 10'h001, {9'h000, (nt >= 11 && nt <= 13)});
        send(8'hE1);
        check("chan", 10'h001, {9'h000, chan_q});
        window(400);
        check("dac cleared", 10'h000, dac_q);
        s2 <= 10'h005;
        window(400);
        check("dac mid", 10'h001, {9'h000, (dac_q > 10'h000 && dac_q < 10'h3FF)});
        send(8'hAD);
        check("gain", 10'h02D, {4'h0, gain_q});
        i_kss_host.shift_bits(9'h0BF, 8);
        repeat (10) @(posedge clock);
        check("gain held", 10'h02D, {4'h0, gain_q});
        check("oe frame", 10'h001, {9'h000, sdo_oe_q});
        i_kss_host.end_frame();
        check("gain max", 10'h03F, {4'h0, gain_q});
        check("oe after", 10'h000, {9'h000, sdo_oe_q});
        send(8'h3F);
        check("freq", 10'h03F, {4'h0, freq_q});
        send(8'h01);
        check("freq", 10'h001, {4'h0, freq_q});
        send(8'hD5);
        check("tc", 10'h015, {5'h00, tc_q});
        send(8'h50);
        check("presc", 10'h008, {6'h00, presc_q});
        send(8'h52);
        check("presc bad", 10'h008, {6'h00, presc_q});
        send(8'h47);
        check("presc", 10'h003, {6'h00, presc_q});
        window(960);
        check("ticks slow", 10'h001, {9'h000, (nt >= 5 && nt <= 7)});
        i_kss_host.shift_bits(9'h03F, 8);
        check("oe tristate", 10'h000, {9'h000, sdo_oe_q});
        i_kss_host.end_frame();
        i_kss_host.shift_bits(9'h02A, 7);
        i_kss_host.end_frame();
        i_kss_host.shift_bits(9'h140, 9);
        i_kss_host.end_frame();
        check_cfg(6'h3F, 6'h3F, 5'h15, 4'h3, 1'b1);
        int_hold <= 1'b1;
        send(8'h81);
        int_hold <= 1'b0;
        check("gain int", 10'h03F, {4'h0, gain_q});
        test_n <= 1'b0;
        repeat (4) @(posedge clock);
        check("test mode", 10'h001, {9'h000, test_mode_q});
        send(8'h81);
        check("gain test", 10'h03F, {4'h0, gain_q});
        test_n <= 1'b1;
        send(8'h81);
        check("gain hold", 10'h001, {4'h0, gain_q});
        send(8'h71);
        check("advanced", 10'h001, {9'h000, advanced_q});
        send(8'h82);
        check("gain adv", 10'h001, {4'h0, gain_q});
        do_reset();
        check("advanced", 10'h000, {9'h000, advanced_q});
        check_cfg(6'h00, 6'h00, 5'h00, 4'h0, 1'b0);
        tally_and_finish();
    end
endmodule // knock_sensor_spi_config_bench

// ### sim/kss_host.sv
// Purpose: host controller model that drives the serial configuration pins
// Assumes: pins change just after a rising clock edge; sclk idles low
// Notes:   sdi returns to its pull-up level after the last bit, between frames
`timescale 1ns/1ps
module kss_host (
    input  wire logic clock,
    output logic      chip_select_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo_q,
    input  wire logic sdo_oe_q
);
    logic [7:0] echo;   // sdo bits seen just before each falling clock
    logic       oe_all; // output enable held through every bit

    // idle bus: deselected, clock low, data pulled high
    initial begin
        chip_select_n = 1'b1;
        sclk          = 1'b0;
        sdi           = 1'b1;
    end

    // select, then clock n bits msb first, select left low
    task automatic shift_bits(input logic [8:0] bits, input int n);
        int i;
        echo   = 8'h00;
        oe_all = 1'b1;
        @(posedge clock);
        sclk          <= 1'b0;
        chip_select_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            sdi  <= bits[i];
            repeat (4) @(posedge clock);
            echo   = {echo[6:0], sdo_q};
            oe_all = oe_all & sdo_oe_q;
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
        end
        sdi <= 1'b1; // released data line back to pull-up
    endtask

    // deselect and leave a gap wide enough for the commit
    task automatic end_frame();
        chip_select_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
endmodule // kss_host
